// ### src/ueb_defines.vh
`ifndef UEB_DEFINES_VH
`define UEB_DEFINES_VH

// Register indices on the plain register port
`define UEB_A_EP2RX   3'h0
`define UEB_A_EP2TX   3'h1
`define UEB_A_CNT0RX  3'h2
`define UEB_A_CNT1RX  3'h3
`define UEB_A_CNT2RX  3'h4
`define UEB_A_CNT2TX  3'h5

// Field positions in the endpoint 2 control registers
`define UEB_B_MOD_HI  7
`define UEB_B_MOD_LO  6
`define UEB_B_FLAG    3
`define UEB_B_TOG     2
`define UEB_B_ST_HI   1
`define UEB_B_ST_LO   0

// Handshake state codes
`define UEB_ST_DIS    2'h0
`define UEB_ST_STALL  2'h1
`define UEB_ST_NAK    2'h2
`define UEB_ST_VALID  2'h3

// Endpoint 2 regime codes
`define UEB_MOD_NORM  2'h0
`define UEB_MOD_UP    2'h1
`define UEB_MOD_DOWN  2'h2

// Endpoint numbers on the packet event port
`define UEB_EP0       2'h0
`define UEB_EP1       2'h1
`define UEB_EP2       2'h2

// Reset values
`define UEB_RST_BYTE  8'h00
`define UEB_RST_CNT5  5'h00
`define UEB_RST_CNT7  7'h00

`endif

// ### src/ueb_ctrl.v
// What this block does
// R1 - USB reset clears low three control bits
// R2 - Regime field picks normal, upload or download
// R3 - Software preloads max size, VALID before download
// R4 - Software preloads max size, NAK before upload
// R5 - Download: hardware OUT, no completion event
// R6 - Download: hardware reopens reception when buffer free
// R7 - Short download packet: normal mode, event, NAK
// R8 - Upload: hardware IN, no completion event
// R9 - Reception register bits 5:4 read zero
// R10 - Reception done flag set; software clears it
// R11 - Transmission done flag set; software clears it
// R12 - Reception toggle flips on matching data
// R13 - Toggles hardware updated and software writable
// R14 - Reception handshake state encoding
// R15 - Transmission handshake state encoding
// R16 - Correct reception forces reception NAK
// R17 - Correct transmission forces transmission NAK
// R18 - Reception state write-locked in download
// R19 - Transmission state write-locked in upload
// R20 - Endpoint 0/1 counters count down received bytes
// R21 - Software derives received bytes by subtraction
// R22 - Endpoint 2 counter holds maximum minus received
// R23 - Registers and counters reset to zero
// R24 - Transmission counter sets next IN length
// R25 - Buffer full/empty handshake with coprocessor
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "ueb_defines.vh"
`default_nettype none

// Down-counter of one reception buffer: software loads the allowed
// size, every accepted packet takes its length off
module ueb_rx_count #(
  parameter WIDTH = 5
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             load,
  input  wire [WIDTH-1:0] load_val,
  input  wire             hit,
  input  wire [WIDTH-1:0] len,
  output wire [WIDTH-1:0] count
);

  reg [WIDTH-1:0] count_reg;
  reg [WIDTH-1:0] count_next;

  // A packet in the same cycle as a write wins over the write
  always @* begin
    count_next = count_reg;
    if (load) begin
      count_next = load_val;
    end
    if (hit) begin
      // Wraps on underflow; the packet engine never exceeds the size
      count_next = count_reg - len; // see R20
    end
  end

  // Counter register, cleared by chip reset only, not by a bus reset
  always @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= {WIDTH{1'b0}}; // see R23
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule // ueb_rx_count

module ueb_ctrl (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       usb_bus_reset,
  input  wire       force_bus_reset,
  input  wire       rx_ok,
  input  wire [1:0] rx_ep,
  input  wire       rx_data1,
  input  wire [6:0] rx_len,
  input  wire       tx_ack,
  input  wire       cop_rx_take,
  input  wire       cop_tx_fill,
  output wire [1:0] ep2_transfer_regime,
  output wire [1:0] ep2_rx_stat,
  output wire [1:0] ep2_tx_stat,
  output wire       rx_toggle_expected,
  output wire       tx_toggle_next,
  output wire [6:0] ep2_tx_len,
  output wire       cop_rx_full,
  output wire       cop_tx_empty,
  output reg        correct_transfer_event
);

  // Control state of endpoint 2
  reg [1:0] mod_reg;
  reg [1:0] mod_next;
  reg       rxflag_reg;
  reg       rxflag_next;
  reg       rxtog_reg;
  reg       rxtog_next;
  reg [1:0] rxst_reg;
  reg [1:0] rxst_next;
  reg       txflag_reg;
  reg       txflag_next;
  reg       txtog_reg;
  reg       txtog_next;
  reg [1:0] txst_reg;
  reg [1:0] txst_next;

  // Byte counters and the kept maximum packet size
  reg [6:0] cnt2rx_reg;
  reg [6:0] cnt2rx_next;
  reg [6:0] rxmax_reg;
  reg [6:0] rxmax_next;
  reg [6:0] cnt2tx_reg;
  reg [6:0] cnt2tx_next;

  // Coprocessor buffer hand-off
  reg       rxfull_reg;
  reg       rxfull_next;
  reg       txempty_reg;
  reg       txempty_next;
  reg       event_next;
  reg [7:0] rdata_next;

  // Decoded conditions
  wire usb_rst   = usb_bus_reset | force_bus_reset;
  wire down_mode = (mod_reg == `UEB_MOD_DOWN);
  wire up_mode   = (mod_reg == `UEB_MOD_UP);
  wire wr_ep2rx  = reg_wr & (reg_addr == `UEB_A_EP2RX);
  wire wr_ep2tx  = reg_wr & (reg_addr == `UEB_A_EP2TX);
  wire wr_cnt0   = reg_wr & (reg_addr == `UEB_A_CNT0RX);
  wire wr_cnt1   = reg_wr & (reg_addr == `UEB_A_CNT1RX);
  wire wr_cnt2rx = reg_wr & (reg_addr == `UEB_A_CNT2RX);
  wire wr_cnt2tx = reg_wr & (reg_addr == `UEB_A_CNT2TX);

  // A repeated packet with the wrong toggle is not a new transfer
  wire rx_hit2  = rx_ok & (rx_ep == `UEB_EP2) &
                  (rx_data1 == rxtog_reg); // see R12
  wire rx_short = (rx_len < cnt2rx_reg); // see R7
  wire rx_hit0  = rx_ok & (rx_ep == `UEB_EP0);
  wire rx_hit1  = rx_ok & (rx_ep == `UEB_EP1);

  // Reception side of endpoint 2
  always @* begin
    mod_next    = mod_reg;
    rxflag_next = rxflag_reg;
    rxtog_next  = rxtog_reg;
    rxst_next   = rxst_reg;
    cnt2rx_next = cnt2rx_reg;
    rxmax_next  = rxmax_reg;
    rxfull_next = rxfull_reg;
    if (wr_ep2rx) begin
      mod_next = reg_wdata[`UEB_B_MOD_HI:`UEB_B_MOD_LO]; // see R2
      // Writing 1 keeps the flag, writing 0 clears it
      rxflag_next = rxflag_reg & reg_wdata[`UEB_B_FLAG]; // see R10
      rxtog_next = reg_wdata[`UEB_B_TOG]; // see R13
      if (!down_mode) begin
        rxst_next = reg_wdata[`UEB_B_ST_HI:`UEB_B_ST_LO]; // see R18
      end
    end
    if (wr_cnt2rx) begin
      cnt2rx_next = reg_wdata[6:0];
      rxmax_next  = reg_wdata[6:0];
    end
    // Buffer taken by the coprocessor reopens the endpoint in download mode
    if (rxfull_reg & cop_rx_take) begin
      rxfull_next = 1'b0; // see R25
      if (down_mode) begin
        rxst_next   = `UEB_ST_VALID; // see R6
        cnt2rx_next = rxmax_reg; // see R6
      end
    end
    // Hardware events come last so that they win over writes
    if (rx_hit2) begin
      rxtog_next  = ~rxtog_reg; // see R12
      cnt2rx_next = cnt2rx_reg - rx_len; // see R22
      rxst_next   = `UEB_ST_NAK; // see R16
      if (down_mode) begin
        rxfull_next = 1'b1; // see R25
        if (rx_short) begin
          mod_next    = `UEB_MOD_NORM; // see R7
          rxflag_next = 1'b1; // see R7
        end
      end else begin
        rxflag_next = 1'b1; // see R10
      end
    end
    // Bus reset clears toggle and state, not flag or regime
    if (usb_rst) begin
      rxtog_next = 1'b0; // see R1
      rxst_next  = `UEB_ST_DIS; // see R1
    end
  end

  // Transmission side of endpoint 2
  always @* begin
    txflag_next  = txflag_reg;
    txtog_next   = txtog_reg;
    txst_next    = txst_reg;
    cnt2tx_next  = cnt2tx_reg;
    txempty_next = txempty_reg;
    if (wr_ep2tx) begin
      txflag_next = txflag_reg & reg_wdata[`UEB_B_FLAG]; // see R11
      txtog_next  = reg_wdata[`UEB_B_TOG]; // see R13
      if (!up_mode) begin
        txst_next = reg_wdata[`UEB_B_ST_HI:`UEB_B_ST_LO]; // see R19
      end
    end
    if (wr_cnt2tx) begin
      cnt2tx_next = reg_wdata[6:0]; // see R24
    end
    // Coprocessor refilled the buffer: in upload mode, offer it to the host
    if (txempty_reg & cop_tx_fill) begin
      txempty_next = 1'b0; // see R25
      if (up_mode) begin
        txst_next = `UEB_ST_VALID; // see R8
      end
    end
    if (tx_ack) begin
      txtog_next = ~txtog_reg; // see R13
      txst_next  = `UEB_ST_NAK; // see R17
      if (up_mode) begin
        txempty_next = 1'b1; // see R8
      end else begin
        txflag_next = 1'b1; // see R11
      end
    end
    if (usb_rst) begin
      txtog_next = 1'b0; // see R1
      txst_next  = `UEB_ST_DIS; // see R1
    end
  end

  // Endpoint 0 and 1 counters: one down-counter design, used twice
  wire [4:0] cnt0_val;
  wire [4:0] cnt1_val;

  ueb_rx_count #(
    .WIDTH    (5)
  ) u_cnt0 (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (wr_cnt0),
    .load_val (reg_wdata[4:0]),
    .hit      (rx_hit0),
    .len      (rx_len[4:0]),
    .count    (cnt0_val)
  );

  ueb_rx_count #(
    .WIDTH    (5)
  ) u_cnt1 (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (wr_cnt1),
    .load_val (reg_wdata[4:0]),
    .hit      (rx_hit1),
    .len      (rx_len[4:0]),
    .count    (cnt1_val)
  );

  // Completion event toward the interrupt logic, silent for full download packets and upload acknowledges
  always @* begin
    event_next = (rx_hit2 & (!down_mode | rx_short)) | // see R5
                 (tx_ack & !up_mode); // see R8
  end

  // Read mux; unmapped indices read zero
  always @* begin
    rdata_next = `UEB_RST_BYTE;
    if (!reg_rd) begin
      rdata_next = `UEB_RST_BYTE;
    end else if (reg_addr == `UEB_A_EP2RX) begin
      rdata_next = {mod_reg, 2'b00, rxflag_reg, rxtog_reg,
                    rxst_reg}; // see R9
    end else if (reg_addr == `UEB_A_EP2TX) begin
      rdata_next = {4'h0, txflag_reg, txtog_reg, txst_reg};
    end else if (reg_addr == `UEB_A_CNT0RX) begin
      rdata_next = {3'h0, cnt0_val};
    end else if (reg_addr == `UEB_A_CNT1RX) begin
      rdata_next = {3'h0, cnt1_val};
    end else if (reg_addr == `UEB_A_CNT2RX) begin
      rdata_next = {1'b0, cnt2rx_reg};
    end else if (reg_addr == `UEB_A_CNT2TX) begin
      rdata_next = {1'b0, cnt2tx_reg};
    end
  end

  // State registers, synchronous active-low reset
  always @(posedge clk) begin
    if (!rst_n) begin
      mod_reg     <= `UEB_MOD_NORM; // see R23
      rxflag_reg  <= 1'b0;
      rxtog_reg   <= 1'b0;
      rxst_reg    <= `UEB_ST_DIS;
      txflag_reg  <= 1'b0;
      txtog_reg   <= 1'b0;
      txst_reg    <= `UEB_ST_DIS;
      cnt2rx_reg  <= `UEB_RST_CNT7;
      rxmax_reg   <= `UEB_RST_CNT7;
      cnt2tx_reg  <= `UEB_RST_CNT7;
      rxfull_reg  <= 1'b0;
      txempty_reg <= 1'b1; // Nothing queued for upload yet
      correct_transfer_event <= 1'b0;
      reg_rdata   <= `UEB_RST_BYTE;
    end else begin
      mod_reg     <= mod_next;
      rxflag_reg  <= rxflag_next;
      rxtog_reg   <= rxtog_next;
      rxst_reg    <= rxst_next; // see R14
      txflag_reg  <= txflag_next;
      txtog_reg   <= txtog_next;
      txst_reg    <= txst_next; // see R15
      cnt2rx_reg  <= cnt2rx_next;
      rxmax_reg   <= rxmax_next;
      cnt2tx_reg  <= cnt2tx_next;
      rxfull_reg  <= rxfull_next;
      txempty_reg <= txempty_next;
      correct_transfer_event <= event_next;
      reg_rdata   <= rdata_next;
    end
  end

  // State toward the packet engine and the coprocessor
  assign ep2_transfer_regime = mod_reg;
  assign ep2_rx_stat         = rxst_reg;
  assign ep2_tx_stat         = txst_reg;
  assign rx_toggle_expected  = rxtog_reg;
  assign tx_toggle_next      = txtog_reg;
  assign ep2_tx_len          = cnt2tx_reg;
  assign cop_rx_full         = rxfull_reg;
  assign cop_tx_empty        = txempty_reg;

endmodule // ueb_ctrl

`default_nettype wire

// ### verif/ueb_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ueb_ctrl_sva (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       usb_bus_reset,
  input wire logic       force_bus_reset,
  input wire logic       rx_ok,
  input wire logic [1:0] rx_ep,
  input wire logic       rx_data1,
  input wire logic       tx_ack,
  input wire logic       cop_rx_take,
  input wire logic       cop_tx_fill,
  input wire logic [1:0] ep2_transfer_regime,
  input wire logic [1:0] ep2_rx_stat,
  input wire logic [1:0] ep2_tx_stat,
  input wire logic       rx_toggle_expected,
  input wire logic       tx_toggle_next,
  input wire logic [6:0] ep2_tx_len,
  input wire logic       cop_rx_full,
  input wire logic       cop_tx_empty,
  input wire logic       correct_transfer_event
);
  // Writes and bus resets may override hardware, so they leave antecedents
  wire logic [1:0] rg  = ep2_transfer_regime;
  wire logic       br  = usb_bus_reset | force_bus_reset;
  wire logic       ok2 = rx_ok && rx_ep == 2'h2 && !br && !reg_wr;
  wire logic       hit = ok2 && rx_data1 == rx_toggle_expected;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rx_nak;
    hit |=> ep2_rx_stat == 2'h2 &&
            rx_toggle_expected != $past(rx_toggle_expected);
  endproperty
  a_rx_nak: assert property (p_rx_nak) else $error("rx nak");
  property p_tog_hold;
    ok2 && !hit && !cop_rx_take |=>
      $stable(ep2_rx_stat) && $stable(rx_toggle_expected);
  endproperty
  a_tog_hold: assert property (p_tog_hold) else $error("bad toggle");
  property p_tx_nak;
    tx_ack && !br && !reg_wr |=> ep2_tx_stat == 2'h2;
  endproperty
  a_tx_nak: assert property (p_tx_nak) else $error("tx nak");
  property p_bus_rst;
    br |=> {ep2_rx_stat, ep2_tx_stat, rx_toggle_expected,
            tx_toggle_next} == 6'h00;
  endproperty
  a_bus_rst: assert property (p_bus_rst) else $error("bus reset");
  property p_rx_lock;
    rg == 2'h2 && reg_wr && reg_addr == 3'h0 && !br && !rx_ok && !cop_rx_take
      |=> $stable(ep2_rx_stat);
  endproperty
  a_rx_lock: assert property (p_rx_lock) else $error("rx lock");
  property p_tx_lock;
    rg == 2'h1 && reg_wr && reg_addr == 3'h1 && !br && !tx_ack && !cop_tx_fill
      |=> $stable(ep2_tx_stat);
  endproperty
  a_tx_lock: assert property (p_tx_lock) else $error("tx lock");
  property p_down_full;
    hit && rg == 2'h2 ##1 rg == 2'h2 |-> !correct_transfer_event;
  endproperty
  a_down_full: assert property (p_down_full) else $error("full");
  property p_short;
    hit && rg == 2'h2 ##1 rg != 2'h2 |->
      correct_transfer_event && ep2_rx_stat == 2'h2;
  endproperty
  a_short: assert property (p_short) else $error("short");
  property p_reopen;
    cop_rx_take && cop_rx_full && rg == 2'h2 && !rx_ok && !reg_wr && !br
      |=> ep2_rx_stat == 2'h3 && !cop_rx_full;
  endproperty
  a_reopen: assert property (p_reopen) else $error("reopen");
  property p_up_ack;
    tx_ack && rg == 2'h1 && !br |=> !correct_transfer_event && cop_tx_empty;
  endproperty
  a_up_ack: assert property (p_up_ack) else $error("upload");
  property p_rsv;
    $past(reg_rd) && $past(reg_addr) == 3'h0 |-> reg_rdata[5:4] == 2'b00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_tx_len;
    reg_wr && reg_addr == 3'h5 |=> ep2_tx_len == $past(reg_wdata[6:0]);
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("tx length");
  // Completions other than download receptions and upload acknowledges must reach the interrupt side
  property p_event;
    (hit && rg != 2'h2) || (tx_ack && rg != 2'h1) |=> correct_transfer_event;
  endproperty
  a_event: assert property (p_event) else $error("event");
  c_down: cover property (hit && rg == 2'h2);
  c_take: cover property (cop_rx_take && cop_rx_full);
  c_up: cover property (tx_ack && rg == 2'h1);
endmodule // ueb_ctrl_sva
bind ueb_ctrl ueb_ctrl_sva chk (
  .clk (clk), .rst_n (rst_n), .reg_addr (reg_addr), .reg_wdata (reg_wdata),
  .reg_wr (reg_wr), .reg_rd (reg_rd), .reg_rdata (reg_rdata),
  .usb_bus_reset (usb_bus_reset), .force_bus_reset (force_bus_reset),
  .rx_ok (rx_ok), .rx_ep (rx_ep), .rx_data1 (rx_data1), .tx_ack (tx_ack),
  .cop_rx_take (cop_rx_take), .cop_tx_fill (cop_tx_fill),
  .ep2_transfer_regime (ep2_transfer_regime), .ep2_rx_stat (ep2_rx_stat),
  .ep2_tx_stat (ep2_tx_stat), .rx_toggle_expected (rx_toggle_expected),
  .tx_toggle_next (tx_toggle_next), .ep2_tx_len (ep2_tx_len),
  .cop_rx_full (cop_rx_full), .cop_tx_empty (cop_tx_empty),
  .correct_transfer_event (correct_transfer_event)
);
`default_nettype wire

// ### verif/ueb_cop_model.sv
`timescale 1ns/100ps
`default_nettype none
module ueb_cop_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] ep2_transfer_regime,
  input  wire logic       cop_rx_full,
  input  wire logic       cop_tx_empty,
  output var  logic       cop_rx_take,
  output var  logic       cop_tx_fill
);
  int unsigned wait_cnt;
  // Random latency, so the USB side meets prompt and slow partners
  always @(posedge clk) begin
    cop_rx_take <= 1'b0;
    cop_tx_fill <= 1'b0;
    if (!rst_n) begin
      wait_cnt <= 0;
    end else if (wait_cnt != 0) begin
      wait_cnt <= wait_cnt - 1;
    end else if (cop_rx_full) begin
      cop_rx_take <= 1'b1;
      wait_cnt <= 1 + $urandom_range(4);
    end else if (cop_tx_empty && ep2_transfer_regime == 2'h1) begin
      cop_tx_fill <= 1'b1;
      wait_cnt <= 1 + $urandom_range(4);
    end
  end
endmodule // ueb_cop_model
`default_nettype wire

// ### verif/test_ueb_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module test_ueb_ctrl;
  logic       clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       usb_bus_reset = 1'b0, force_bus_reset = 1'b0, rd_d = 1'b0;
  logic       rx_ok = 1'b0, rx_data1 = 1'b0, tx_ack = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0] rx_ep = 2'h0;
  logic [6:0] rx_len = 7'h00;
  wire  [7:0] reg_rdata;
  wire  [1:0] ep2_transfer_regime, ep2_rx_stat, ep2_tx_stat;
  wire  [6:0] ep2_tx_len;
  wire        rx_toggle_expected, tx_toggle_next, cop_rx_take, cop_tx_fill;
  wire        cop_rx_full, cop_tx_empty, correct_transfer_event;
  logic [7:0] exp_q[$];
  int         n_errors = 0;
  int         compares = 0;
  ueb_ctrl uut (
    .clk (clk), .rst_n (rst_n), .reg_addr (reg_addr),
    .reg_wdata (reg_wdata), .reg_wr (reg_wr), .reg_rd (reg_rd),
    .reg_rdata (reg_rdata), .usb_bus_reset (usb_bus_reset),
    .force_bus_reset (force_bus_reset), .rx_ok (rx_ok), .rx_ep (rx_ep),
    .rx_data1 (rx_data1), .rx_len (rx_len), .tx_ack (tx_ack),
    .cop_rx_take (cop_rx_take), .cop_tx_fill (cop_tx_fill),
    .ep2_transfer_regime (ep2_transfer_regime), .ep2_rx_stat (ep2_rx_stat),
    .ep2_tx_stat (ep2_tx_stat), .rx_toggle_expected (rx_toggle_expected),
    .tx_toggle_next (tx_toggle_next), .ep2_tx_len (ep2_tx_len),
    .cop_rx_full (cop_rx_full), .cop_tx_empty (cop_tx_empty),
    .correct_transfer_event (correct_transfer_event)
  );
  ueb_cop_model cop (
    .clk (clk), .rst_n (rst_n), .ep2_transfer_regime (ep2_transfer_regime),
    .cop_rx_full (cop_rx_full), .cop_tx_empty (cop_tx_empty),
    .cop_rx_take (cop_rx_take), .cop_tx_fill (cop_tx_fill)
  );
  always #10 clk = ~clk;
  task automatic close_out;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input [7:0] e, input [7:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: want %h got %h", $time, e, g);
    end
  endtask
  // Strobes are lowered with an idle edge after, so no net is set twice
  task automatic wr(input [2:0] a, input [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input [2:0] a, input [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk) reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pkt(input [1:0] ep, input d1, input [6:0] l);
    rx_ok <= 1'b1;
    rx_ep <= ep;
    rx_data1 <= d1;
    rx_len <= l;
    @(posedge clk) rx_ok <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ack;
    tx_ack <= 1'b1;
    @(posedge clk) tx_ack <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_st(input tx, input [1:0] s);
    int i;
    for (i = 0; i < 20 && (tx ? ep2_tx_stat : ep2_rx_stat) !== s; i++)
      @(posedge clk);
    if (i == 20) begin
      n_errors++;
      $display("unexpected at %0t: want %h got %h", $time, s,
               tx ? ep2_tx_stat : ep2_rx_stat);
    end
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) cmp(exp_q.pop_front(), reg_rdata);
  end
  initial begin
    #100000;
    n_errors++;
    close_out;
  end
  initial begin
    logic [6:0] ln;
    int e;
    void'($urandom(32'hbbd2));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (e = 0; e < 8; e++) rd(e[2:0], 8'h00);
    wr(0, 8'hff);
    rd(0, 8'hc7);
    wr(0, 8'h03);
    wr(4, 8'h40);
    ln = 7'($urandom % 63 + 1);
    pkt(2, 1'b0, ln);
    rd(0, 8'h0e);
    pkt(2, 1'b0, 7'h05);
    rd(4, 8'h40 - ln);
    wr(0, 8'h06);
    rd(0, 8'h06);
    for (e = 0; e < 2; e++) begin
      ln = 7'($urandom % 32);
      wr(e[2:0] + 3'h2, 8'h1f);
      pkt(e[1:0], e[0], ln);
      rd(e[2:0] + 3'h2, 8'h1f - ln);
    end
    wr(4, 8'h40);
    wr(0, 8'h83);
    pkt(2, 1'b0, 7'h40);
    wait_st(1'b0, 2'h3);
    wr(0, 8'h85);
    rd(0, 8'h87);
    rd(4, 8'h40);
    pkt(2, 1'b1, 7'h0a);
    rd(0, 8'h0a);
    rd(4, 8'h36);
    wr(1, 8'h03);
    ack;
    rd(1, 8'h0e);
    wr(5, 8'h40);
    wr(1, 8'h02);
    wr(0, 8'h48);
    wait_st(1'b1, 2'h3);
    wr(1, 8'h01);
    rd(1, 8'h03);
    ack;
    wait_st(1'b1, 2'h3);
    rd(5, 8'h40);
    wr(0, 8'h0f);
    force_bus_reset <= 1'b1;
    @(posedge clk) force_bus_reset <= 1'b0;
    rd(0, 8'h08);
    wr(1, 8'h07);
    usb_bus_reset <= 1'b1;
    @(posedge clk) usb_bus_reset <= 1'b0;
    rd(1, 8'h00);
    repeat (2) @(posedge clk);
    if (exp_q.size() != 0) n_errors++;
    close_out;
  end
endmodule // test_ueb_ctrl
`default_nettype wire
